// ---- logic/swa_core.v ----
`timescale 1ns/1ps
`default_nettype none
`include "swa_defs.vh"

module swa_core (
   input wire clock_i,                      // 40 MHz block clock
   input wire resetn_i,                     // Asynchronous active-low reset
   input wire scl_i,                        // Serial clock line level
   input wire sda_i,                        // Serial data line level
   output reg scl_o,                        // Serial clock drive value, always 0
   output reg scl_oe_o,                     // Serial clock pulled low
   output reg sda_o,                        // Serial data drive value, always 0
   output reg sda_oe_o,                     // Serial data pulled low
   input wire master_i,                     // Device acts as master
   input wire transmit_i,                   // Device transmits data bytes
   input wire wait_timing_select_i,         // 0: eighth clock, 1: ninth clock
   input wire address_wait_select_i,        // Slave address wait: 0 ninth, 1 eighth
   input wire ack_enable_i,                 // Acknowledge received data
   input wire wait_release_i,               // Pulse: cancel wait
   input wire start_request_i,              // Pulse: start requested
   input wire stop_request_i,               // Pulse: stop requested
   input wire stop_irq_enable_i,            // Interrupt on stop condition
   input wire start_irq_enable_i,           // Interrupt on start condition
   input wire bus_release_request_i,        // Pulse: leave the bus
   input wire sva_wr_i,                     // Pulse: load local address
   input wire [6:0] sva_wdata_i,            // Local slave address
   input wire shift_wr_i,                   // Pulse: write shift register
   input wire [7:0] shift_wdata_i,          // Byte to transmit
   output reg [7:0] serial_shift_o,         // Shift register contents
   output reg [6:0] local_slave_address_o,  // Local slave address
   output reg serial_bus_irq_o,             // One-cycle interrupt pulse
   output reg extension_code_flag_o,        // Extension code received
   output reg address_match_flag_o,         // Address matched
   output reg [2:0] ext_code_kind_o,        // Decoded extension code
   output reg tx_error_o,                   // Line differs from written byte
   output reg wait_o,                       // Wait state active
   output reg rx_valid_o,                   // Received byte available
   input wire rx_ready_i,                   // Received byte taken
   output reg [7:0] rx_data_o               // Received byte
);

   // ----------------------------------------------------------------------
   // Phase states
   // ----------------------------------------------------------------------
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_ADDR = 4'b0010;
   localparam [3:0] ST_DATA = 4'b0100;
   localparam [3:0] ST_STANDBY = 4'b1000;

   function ext_hi;
      input [7:0] b;
      begin
         ext_hi = (b[7:4] == `SWA_EXT_HI_LOW) || (b[7:4] == `SWA_EXT_HI_HIGH);
      end
   endfunction

   function [2:0] ext_kind;
      input [6:0] a;
      begin
         if (a == `SWA_ADDR_GCALL)
            ext_kind = `SWA_EXT_GCALL;
         else if (a == `SWA_ADDR_CBUS)
            ext_kind = `SWA_EXT_CBUS;
         else if (a == `SWA_ADDR_OTHER_BUS)
            ext_kind = `SWA_EXT_OTHER_BUS;
         else if (a[6:2] == `SWA_TENBIT_PREFIX)
            ext_kind = `SWA_EXT_TENBIT;
         else
            ext_kind = `SWA_EXT_RESERVED;
      end
   endfunction

   // ----------------------------------------------------------------------
   // Reset release and pin sampling
   // ----------------------------------------------------------------------
   reg rst_meta_reg;
   reg rst_sync_reg;
   wire rstn;
   wire [1:0] pins;
   wire scl_s;
   wire sda_s;

   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   assign rstn = rst_sync_reg;

   swa_sync #(.WIDTH(2)) u_sync (
      .clock_i(clock_i),
      .resetn_i(rstn),
      .async_i({scl_i, sda_i}),
      .sync_o(pins)
   );

   assign scl_s = pins[1];
   assign sda_s = pins[0];

   // ----------------------------------------------------------------------
   // Bus events
   // ----------------------------------------------------------------------
   reg scl_q_reg;
   reg sda_q_reg;
   reg [3:0] state_reg;
   reg [3:0] bit_cnt_reg;
   reg [7:0] tx_byte_reg;
   reg sel_reg;
   reg match_reg;
   reg wait_reg;
   reg pend_valid_reg;
   reg [7:0] pend_data_reg;
   wire scl_rise = scl_s & ~scl_q_reg;
   wire scl_fall = ~scl_s & scl_q_reg;
   wire start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
   wire stop_det = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
   wire fall8 = scl_fall & (bit_cnt_reg == `SWA_CLK_EARLY);
   wire fall9 = scl_fall & (bit_cnt_reg == `SWA_CLK_LATE);
   wire in_addr = (state_reg == ST_ADDR);
   wire in_data = (state_reg == ST_DATA);
   wire addr_ext = ext_hi(serial_shift_o);
   wire addr_match = (serial_shift_o[7:1] == local_slave_address_o);
   wire data_own = in_data & (master_i | sel_reg);
   wire data_fall = wait_timing_select_i ? fall9 : fall8;
   wire release_any = wait_release_i | shift_wr_i | start_request_i | stop_request_i;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire fifo_take = fifo_out_valid & (~rx_valid_o | rx_ready_i);

   // ----------------------------------------------------------------------
   // Interrupt and wait decision
   // ----------------------------------------------------------------------
   reg event_now;

   always @*
   begin
      event_now = 1'b0;
      if (in_addr & master_i)
         event_now = fall9;
      else if (in_addr)
      begin
         // By the ninth fall the acknowledge bit has been shifted in, so the
         // late case relies on the match latched at the eighth fall.
         if (fall8 & addr_ext)
            event_now = 1'b1;
         else if (fall8 & addr_match & address_wait_select_i)
            event_now = 1'b1;
         else if (fall9 & match_reg & ~extension_code_flag_o & ~address_wait_select_i)
            event_now = 1'b1;
      end
      else if (data_own)
         event_now = data_fall;
   end

   // ----------------------------------------------------------------------
   // Data line drive, changed only while the clock is low
   // ----------------------------------------------------------------------
   reg drive_low;
   wire tx_phase = (in_addr & master_i) | (data_own & transmit_i);

   always @*
   begin
      drive_low = 1'b0;
      if (tx_phase & (bit_cnt_reg < `SWA_CLK_EARLY))
         drive_low = ~tx_byte_reg[3'h7 - bit_cnt_reg[2:0]];
      else if (bit_cnt_reg == `SWA_CLK_EARLY)
      begin
         if (in_addr & ~master_i & sel_reg)
            drive_low = match_reg | ack_enable_i;
         else if (data_own & ~transmit_i)
            drive_low = ack_enable_i;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   always @(posedge clock_i or negedge rstn)
   begin
      if (!rstn)
      begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
         state_reg <= ST_IDLE;
         bit_cnt_reg <= `SWA_CNT_RESET;
         tx_byte_reg <= 8'hFF;
         sel_reg <= 1'b0;
         match_reg <= 1'b0;
         wait_reg <= 1'b0;
         pend_valid_reg <= 1'b0;
         pend_data_reg <= 8'h00;
         scl_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         serial_shift_o <= 8'h00;
         local_slave_address_o <= `SWA_SVA_RESET;
         serial_bus_irq_o <= 1'b0;
         extension_code_flag_o <= 1'b0;
         address_match_flag_o <= 1'b0;
         ext_code_kind_o <= `SWA_EXT_NONE;
         tx_error_o <= 1'b0;
         wait_o <= 1'b0;
         rx_valid_o <= 1'b0;
         rx_data_o <= 8'h00;
      end
      else
      begin
         scl_q_reg <= scl_s;
         sda_q_reg <= sda_s;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         serial_bus_irq_o <= 1'b0;
         // Only an explicit load changes the local address.
         if (sva_wr_i)
            local_slave_address_o <= sva_wdata_i;
         if (shift_wr_i)
         begin
            tx_byte_reg <= shift_wdata_i;
            serial_shift_o <= shift_wdata_i;
         end
         else if (scl_rise)
            serial_shift_o <= {serial_shift_o[6:0], sda_s};
         if (scl_rise & ~state_reg[0])
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
         if (release_any)
            wait_reg <= 1'b0;
         if (event_now)
         begin
            serial_bus_irq_o <= 1'b1;
            wait_reg <= 1'b1;
         end
         if (fall8 & tx_phase)
            tx_error_o <= (serial_shift_o != tx_byte_reg);
         if (fall8 & in_addr & ~master_i)
         begin
            // Flags come from the hardware compare alone.
            extension_code_flag_o <= addr_ext;
            address_match_flag_o <= addr_match;
            ext_code_kind_o <= addr_ext ? ext_kind(serial_shift_o[7:1]) : `SWA_EXT_NONE;
            sel_reg <= addr_match | addr_ext;
            match_reg <= addr_match;
         end
         // A received byte waits here while the buffer is full; the clock is
         // stretched meanwhile so no byte is ever overwritten.
         if (fall8 & data_own & ~transmit_i)
         begin
            pend_valid_reg <= 1'b1;
            pend_data_reg <= serial_shift_o;
         end
         else if (fifo_in_ready)
            pend_valid_reg <= 1'b0;
         if (fall9)
         begin
            bit_cnt_reg <= `SWA_CNT_RESET;
            if (in_addr)
               state_reg <= (master_i | sel_reg) ? ST_DATA : ST_STANDBY;
         end
         if (bus_release_request_i)
         begin
            state_reg <= ST_STANDBY;
            sel_reg <= 1'b0;
            wait_reg <= 1'b0;
         end
         if (stop_det)
         begin
            state_reg <= ST_IDLE;
            sel_reg <= 1'b0;
            wait_reg <= 1'b0;
            bit_cnt_reg <= `SWA_CNT_RESET;
            serial_bus_irq_o <= stop_irq_enable_i;
         end
         if (start_det)
         begin
            state_reg <= ST_ADDR;
            sel_reg <= 1'b0;
            match_reg <= 1'b0;
            wait_reg <= 1'b0;
            bit_cnt_reg <= `SWA_CNT_RESET;
            extension_code_flag_o <= 1'b0;
            address_match_flag_o <= 1'b0;
            ext_code_kind_o <= `SWA_EXT_NONE;
            serial_bus_irq_o <= start_irq_enable_i;
         end
         if (~scl_s)
            sda_oe_o <= drive_low & ~state_reg[3] & ~bus_release_request_i;
         scl_oe_o <= (event_now | (wait_reg & ~release_any & ~bus_release_request_i)
                     | pend_valid_reg) & ~stop_det & ~start_det;
         wait_o <= (event_now | (wait_reg & ~release_any & ~bus_release_request_i))
                   & ~stop_det & ~start_det;
         if (fifo_take)
         begin
            rx_valid_o <= 1'b1;
            rx_data_o <= fifo_out_data;
         end
         else if (rx_ready_i)
            rx_valid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Receive buffer
   // ----------------------------------------------------------------------
   swa_fifo #(
      .WIDTH(`SWA_FIFO_WIDTH),
      .DEPTH(`SWA_FIFO_DEPTH),
      .AW(`SWA_FIFO_AW)
   ) u_fifo (
      .clock_i(clock_i),
      .resetn_i(rstn),
      .in_valid_i(pend_valid_reg),
      .in_ready_o(fifo_in_ready),
      .in_data_i(pend_data_reg),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_take),
      .out_data_o(fifo_out_data)
   );

endmodule // swa_core

`default_nettype wire

// ---- logic/swa_defs.vh ----
`ifndef SWA_DEFS_VH
`define SWA_DEFS_VH

// ----------------------------------------------------------------------
// Byte timing in serial clocks
// ----------------------------------------------------------------------
`define SWA_CLK_EARLY 4'h8
`define SWA_CLK_LATE 4'h9
`define SWA_CNT_RESET 4'h0

// ----------------------------------------------------------------------
// Address decoding
// ----------------------------------------------------------------------
`define SWA_EXT_HI_LOW 4'h0
`define SWA_EXT_HI_HIGH 4'hF
`define SWA_ADDR_GCALL 7'h00
`define SWA_ADDR_CBUS 7'h01
`define SWA_ADDR_OTHER_BUS 7'h02
`define SWA_TENBIT_PREFIX 5'h1E
`define SWA_SVA_RESET 7'h00

// ----------------------------------------------------------------------
// Extension code kinds
// ----------------------------------------------------------------------
`define SWA_EXT_NONE 3'h0
`define SWA_EXT_GCALL 3'h1
`define SWA_EXT_CBUS 3'h2
`define SWA_EXT_OTHER_BUS 3'h3
`define SWA_EXT_TENBIT 3'h4
`define SWA_EXT_RESERVED 3'h5

// ----------------------------------------------------------------------
// Receive buffer
// ----------------------------------------------------------------------
`define SWA_FIFO_WIDTH 8
`define SWA_FIFO_DEPTH 32
`define SWA_FIFO_AW 5

`endif

// ---- logic/swa_sync.v ----
`timescale 1ns/1ps
`default_nettype none

module swa_sync #(
   parameter WIDTH = 2
)(
   input wire clock_i,                  // Block clock
   input wire resetn_i,                 // Active-low reset
   input wire [WIDTH-1:0] async_i,      // Asynchronous levels
   output wire [WIDTH-1:0] sync_o       // Synchronised levels
);

   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] sync_reg;

   // Idle bus lines are high, so reset to ones to avoid false conditions.
   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_reg <= {WIDTH{1'b1}};
         sync_reg <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule // swa_sync

`default_nettype wire

// ---- logic/swa_fifo.v ----
`timescale 1ns/1ps
`default_nettype none

module swa_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32,
   parameter AW = 5
)(
   input wire clock_i,                  // Block clock
   input wire resetn_i,                 // Active-low reset
   input wire in_valid_i,               // Write request
   output wire in_ready_o,              // Room available
   input wire [WIDTH-1:0] in_data_i,    // Write data
   output wire out_valid_o,             // Data available
   input wire out_ready_i,              // Read accept
   output wire [WIDTH-1:0] out_data_o   // Read data
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_reg;
   reg [AW-1:0] rd_ptr_reg;
   reg [AW:0] count_reg;
   wire do_wr;
   wire do_rd;

   assign in_ready_o = (count_reg != DEPTH[AW:0]);
   assign out_valid_o = (count_reg != {(AW+1){1'b0}});
   assign do_wr = in_valid_i & in_ready_o;
   assign do_rd = out_ready_i & out_valid_o;
   assign out_data_o = mem[rd_ptr_reg];

   always @(posedge clock_i)
   begin
      if (do_wr)
         mem[wr_ptr_reg] <= in_data_i;
   end

   always @(posedge clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_rd)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (do_wr & ~do_rd)
            count_reg <= count_reg + 1'b1;
         else if (do_rd & ~do_wr)
            count_reg <= count_reg - 1'b1;
      end
   end

endmodule // swa_fifo

`default_nettype wire

// ---- dv/swa_core_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module swa_core_asserts (
   input wire logic clock_i,                     // Block clock
   input wire logic resetn_i,                    // Active-low reset
   input wire logic scl_i,                       // Clock line level
   input wire logic scl_o,                       // Clock drive value
   input wire logic scl_oe_o,                    // Clock pull-low
   input wire logic sda_o,                       // Data drive value
   input wire logic wait_release_i,              // Wait release pulse
   input wire logic shift_wr_i,                  // Shift write pulse
   input wire logic start_request_i,             // Start request pulse
   input wire logic stop_request_i,              // Stop request pulse
   input wire logic bus_release_request_i,       // Bus release pulse
   input wire logic sva_wr_i,                    // Address load pulse
   input wire logic serial_bus_irq_o,            // Interrupt pulse
   input wire logic extension_code_flag_o,       // Extension flag
   input wire logic [2:0] ext_code_kind_o,       // Extension kind
   input wire logic [6:0] local_slave_address_o, // Local address
   input wire logic wait_o                       // Wait state
);
   // While the clock line is held low no bus edge can end a wait by itself.
   wire any_rel = wait_release_i | shift_wr_i | start_request_i | stop_request_i;

   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   chk_wait_holds_scl: assert property (wait_o |-> scl_oe_o)
      else $error("wait without clock stretch");
   chk_release_ends: assert property (wait_o && any_rel |=> !wait_o)
      else $error("wait not released");
   chk_wait_persists: assert property (wait_o && !any_rel && !bus_release_request_i |=> wait_o)
      else $error("wait dropped alone");
   chk_wait_low_scl: assert property ($rose(wait_o) |-> !scl_i && !$past(scl_i, 2))
      else $error("wait not after clock fall");
   chk_irq_with_wait: assert property ($rose(wait_o) |-> serial_bus_irq_o)
      else $error("wait without interrupt");
   chk_irq_single: assert property (serial_bus_irq_o |=> !serial_bus_irq_o)
      else $error("interrupt too long");
   chk_drive_zero: assert property (!scl_o && !sda_o)
      else $error("line driven high");
   chk_addr_kept: assert property (!sva_wr_i |=> $stable(local_slave_address_o))
      else $error("local address changed");
   chk_ext_irq: assert property ($rose(extension_code_flag_o) |-> serial_bus_irq_o && ext_code_kind_o != 3'h0)
      else $error("extension code without interrupt");
endmodule // swa_core_asserts

bind swa_core swa_core_asserts u_swa_core_asserts (.clock_i, .resetn_i, .scl_i, .scl_o, .scl_oe_o,
   .sda_o, .wait_release_i, .shift_wr_i, .start_request_i, .stop_request_i, .bus_release_request_i,
   .sva_wr_i, .serial_bus_irq_o, .extension_code_flag_o, .ext_code_kind_o, .local_slave_address_o,
   .wait_o);

`default_nettype wire

// ---- dv/swa_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module swa_bus_model (
   input wire logic scl_line_i, // Resolved clock line
   input wire logic sda_line_i, // Resolved data line
   output var logic scl_low_o,  // Pull clock line low
   output var logic sda_low_o   // Pull data line low
);
   int nfalls = 0;
   logic busy = 1'b0;
   logic ack = 1'b1;

   initial
   begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // The low phase is longer than the block's reaction time, so a stretch
   // starts before this model lets go and no glitch reaches the line.
   task automatic clk_bit(input logic b, output logic seen);
      #70 sda_low_o = !b;
      #70 scl_low_o = 1'b0;
      wait (scl_line_i === 1'b1);
      #30 seen = sda_line_i;
      #30 scl_low_o = 1'b1;
      nfalls = nfalls + 1;
   endtask

   task automatic send_byte(input logic [7:0] b);
      logic s;
      busy = 1'b1;
      nfalls = 0;
      for (int i = 7; i >= 0; i--)
      begin
         clk_bit(b[i], s);
      end
      clk_bit(1'b1, ack);
      #200 busy = 1'b0;
   endtask

   task automatic start_cond;
      sda_low_o = 1'b0;
      #50 scl_low_o = 1'b0;
      wait (scl_line_i === 1'b1);
      #100 sda_low_o = 1'b1;
      #100 scl_low_o = 1'b1;
      #50;
   endtask

   task automatic stop_cond;
      sda_low_o = 1'b1;
      #50 scl_low_o = 1'b0;
      wait (scl_line_i === 1'b1);
      #100 sda_low_o = 1'b0;
      #200;
   endtask
endmodule // swa_bus_model

`default_nettype wire

// ---- dv/swa_core_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module swa_core_test;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic master = 1'b0, transmit = 1'b0, wtim = 1'b0, aws = 1'b0, acke = 1'b0;
   logic spie = 1'b0, stie = 1'b0, rx_ready = 1'b0;
   logic [5:0] pls = 6'h00;
   logic [6:0] sva_wdata = 7'h00;
   logic [7:0] shift_wdata = 8'h00;
   logic scl_low, sda_low, scl_oe, sda_oe, wait_o, irq, ext_flag, match_flag, tx_error, rx_valid;
   logic [7:0] shift_q, rx_data;
   logic [6:0] sva_q;
   logic [2:0] ext_kind;
   logic [7:0] codes [4] = '{8'h00, 8'h02, 8'h04, 8'hF0};
   wire scl = !(scl_low | scl_oe);
   wire sda = !(sda_low | sda_oe);
   int n_fail = 0, num_checks = 0, n_irq = 0, cycles = 0, base, k;

   swa_core u_swa_core (.clock_i(clock_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
      .scl_o(), .scl_oe_o(scl_oe), .sda_o(), .sda_oe_o(sda_oe), .master_i(master),
      .transmit_i(transmit), .wait_timing_select_i(wtim), .address_wait_select_i(aws),
      .ack_enable_i(acke), .wait_release_i(pls[0]), .shift_wr_i(pls[1]),
      .start_request_i(pls[2]), .stop_request_i(pls[3]), .bus_release_request_i(pls[4]),
      .sva_wr_i(pls[5]), .stop_irq_enable_i(spie), .start_irq_enable_i(stie),
      .sva_wdata_i(sva_wdata), .shift_wdata_i(shift_wdata), .serial_shift_o(shift_q),
      .local_slave_address_o(sva_q), .serial_bus_irq_o(irq), .extension_code_flag_o(ext_flag),
      .address_match_flag_o(match_flag), .ext_code_kind_o(ext_kind), .tx_error_o(tx_error),
      .wait_o(wait_o), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data));

   swa_bus_model u_swa_bus_model (.scl_line_i(scl), .sda_line_i(sda), .scl_low_o(scl_low),
      .sda_low_o(sda_low));

   always #12.5 clock_i = ~clock_i;

   // ----------------------------------------------------------------------
   // Interrupt counting and hang guard
   // ----------------------------------------------------------------------
   always @(posedge clock_i)
   begin
      cycles++;
      if (irq === 1'b1)
         n_irq++;
      if (cycles == 20000)
      begin
         n_fail++;
         report_and_stop();
      end
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      if (n_fail == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic pulse(input int idx);
      @(posedge clock_i);
      #2 pls[idx] = 1'b1;
      @(posedge clock_i);
      #2 pls = 6'h00;
   endtask

   // Sends one byte and records after how many clock falls the wait began;
   // zero means no wait. A seen wait is ended by release method how.
   task automatic xfer(input logic [7:0] b, input logic [7:0] n, input int how);
      int c;
      logic [7:0] seen;
      c = 0;
      seen = 8'h00;
      fork
         u_swa_bus_model.send_byte(b);
         begin
            do
            begin
               @(posedge clock_i);
               c++;
            end
            while (wait_o !== 1'b1 && (u_swa_bus_model.busy || c < 4) && c < 3000);
            if (wait_o === 1'b1)
               seen = 8'(u_swa_bus_model.nfalls);
            check(seen, n, "wait clock");
            if (wait_o === 1'b1)
               pulse(how);
         end
      join
   endtask

   initial
   begin
      repeat (6) @(posedge clock_i);
      #2 resetn_i = 1'b1;
      repeat (6) @(posedge clock_i);
      #2 check(wait_o, 0, "idle wait");
      sva_wdata = 7'h2A;
      pulse(5);
      stie = 1'b1;
      base = n_irq;
      u_swa_bus_model.start_cond();
      check(8'(n_irq - base), 1, "start irq");
      xfer(8'h54, 9, 0);
      check(u_swa_bus_model.ack, 0, "address ack");
      check(match_flag, 1, "match flag");
      acke = 1'b1;
      xfer(8'hA5, 8, 1);
      check(rx_data, 8'hA5, "rx data");
      wtim = 1'b1;
      for (int i = 0; i < 32; i++)
         xfer(8'(i), 9, i % 4);
      for (int i = 0; i < 33; i++)
      begin
         @(posedge clock_i);
         #2 k = 0;
         while (rx_valid !== 1'b1 && k < 10)
         begin
            @(posedge clock_i);
            #2 k++;
         end
         check(rx_data, (i == 0) ? 8'hA5 : 8'(i - 1), "drained byte");
         rx_ready = 1'b1;
         @(posedge clock_i);
         #2 rx_ready = 1'b0;
      end
      repeat (4) @(posedge clock_i);
      #2 check(rx_valid, 0, "buffer empty");
      spie = 1'b1;
      base = n_irq;
      u_swa_bus_model.stop_cond();
      check(8'(n_irq - base), 1, "stop irq");
      spie = 1'b0;
      stie = 1'b0;
      aws = 1'b1;
      acke = 1'b0;
      base = n_irq;
      u_swa_bus_model.start_cond();
      xfer(8'h54, 8, 3);
      check(8'(n_irq - base), 1, "masked start irq");
      check(u_swa_bus_model.ack, 0, "early address ack");
      u_swa_bus_model.start_cond();
      base = n_irq;
      xfer(8'hAA, 0, 0);
      check(8'(n_irq - base), 0, "foreign irq");
      check(u_swa_bus_model.ack, 1, "foreign ack");
      acke = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         u_swa_bus_model.start_cond();
         xfer(codes[i], 8, 4);
         check(ext_flag, 1, "extension flag");
         check(ext_kind, 8'(i + 1), "extension kind");
         check(u_swa_bus_model.ack, 1, "released ack");
      end
      check(sva_q, 8'h2A, "local address");
      sva_wdata = 7'h7A;
      pulse(5);
      u_swa_bus_model.start_cond();
      xfer(8'hF4, 8, 0);
      check({ext_flag, match_flag}, 8'h03, "ten-bit flags");
      check(u_swa_bus_model.ack, 0, "ten-bit ack");
      u_swa_bus_model.stop_cond();
      master = 1'b1;
      transmit = 1'b1;
      wtim = 1'b0;
      shift_wdata = 8'hA4;
      pulse(1);
      shift_wdata = 8'h5A;
      u_swa_bus_model.start_cond();
      xfer(8'hFF, 9, 1);
      xfer(8'hFF, 8, 0);
      check(tx_error, 0, "clean send");
      check(shift_q, 8'hB5, "line echo");
      pulse(1);
      xfer(8'h52, 8, 0);
      check(tx_error, 1, "corrupted send");
      u_swa_bus_model.stop_cond();
      report_and_stop();
   end
endmodule // swa_core_test

`default_nettype wire
